// [src/sw_clock_pkg.sv]
// Purpose: Shared constants for the switching clock control block.
// Assumes: 200 MHz system clock, synchronous active-low reset.
// Notes: Register offsets are byte addresses on the plain register port.
package sw_clock_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned FSW_300_KHZ = 300;
  localparam int unsigned FSW_400_KHZ = 400;
  localparam int unsigned FSW_450_KHZ = 450;
  localparam int unsigned DITHER_SLOW_KHZ = 10;
  localparam int unsigned DITHER_FAST_KHZ = 25;
  localparam int unsigned DITHER_SPAN_PCT = 10;
  // Sync-in windows in kHz, per frequency setting
  localparam int unsigned WIN_300_MIN_KHZ = 250;
  localparam int unsigned WIN_300_MAX_KHZ = 353;
  localparam int unsigned WIN_400_MIN_KHZ = 334;
  localparam int unsigned WIN_400_MAX_KHZ = 470;
  localparam int unsigned WIN_450_MIN_KHZ = 376;
  localparam int unsigned WIN_450_MAX_KHZ = 530;
  localparam int unsigned RELOCK_COUNT = 8;
  localparam int unsigned VOUT_STEP_MV = 20;
  localparam int unsigned VOUT_SS_TARGET_MV = 5000;
  localparam logic [11:0] VOUT_SS_CODE = 12'(VOUT_SS_TARGET_MV / VOUT_STEP_MV);
  localparam int unsigned ILIM_STEP_MA = 50;
  localparam int unsigned DROOP_MAX_MV = 500;
  localparam int unsigned SS_STEP_NS = 1000;
  localparam int unsigned SS_STEP_CYC = SS_STEP_NS * (CLK_HZ / 1_000_000) / 1000;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_VOUT = 8'h04;
  localparam logic [7:0] REG_ILIM = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  // Control field positions
  localparam int CTRL_FSEL_LO = 0;
  localparam int CTRL_DITHER_EN = 2;
  localparam int CTRL_DITHER_FAST = 3;
  localparam int CTRL_SYNC_OUT = 4;
  localparam int CTRL_PHASE_LO = 5;
  localparam int CTRL_SS_START = 7;
  localparam int CTRL_DROOP_LO = 8;
  localparam int CTRL_DROOP_EN = 10;
  localparam int CTRL_PPS = 11;
  localparam int CTRL_RUN = 12;
  localparam logic [12:0] CTRL_RESET = 13'h0000;
  localparam logic [6:0] ILIM_RESET = 7'h00;
  typedef enum logic [1:0] {FSEL_300, FSEL_400, FSEL_450, FSEL_RSVD} fsel_t;
  typedef enum logic [1:0] {PH_0, PH_90, PH_120, PH_180} phase_t;
  function automatic int unsigned khz_to_cyc(input int unsigned khz);
    return CLK_HZ / (khz * 1000);
  endfunction : khz_to_cyc
endpackage : sw_clock_pkg

// [src/period_window.sv]
// Purpose: Period window lookup for the selected switching frequency.
// Assumes: Registered outputs, one cycle of latency after a change of setting.
// Notes: Holds nominal, dither and sync-in window periods in clk cycles.
module period_window
  import sw_clock_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire sw_clock_pkg::fsel_t fsel,
  output logic [15:0] nom_cyc_q,
  output logic [15:0] span_cyc_q,
  output logic [15:0] win_min_cyc_q,
  output logic [15:0] win_max_cyc_q
);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      nom_cyc_q <= 16'(khz_to_cyc(FSW_300_KHZ));
      span_cyc_q <= 16'(khz_to_cyc(FSW_300_KHZ) * DITHER_SPAN_PCT / 100);
      win_min_cyc_q <= 16'(khz_to_cyc(WIN_300_MAX_KHZ));
      win_max_cyc_q <= 16'(khz_to_cyc(WIN_300_MIN_KHZ));
    end else begin
      unique case (fsel)
        FSEL_400: begin
          nom_cyc_q <= 16'(khz_to_cyc(FSW_400_KHZ));
          span_cyc_q <= 16'(khz_to_cyc(FSW_400_KHZ) * DITHER_SPAN_PCT / 100);
          win_min_cyc_q <= 16'(khz_to_cyc(WIN_400_MAX_KHZ));
          win_max_cyc_q <= 16'(khz_to_cyc(WIN_400_MIN_KHZ));
        end
        FSEL_450: begin
          nom_cyc_q <= 16'(khz_to_cyc(FSW_450_KHZ));
          span_cyc_q <= 16'(khz_to_cyc(FSW_450_KHZ) * DITHER_SPAN_PCT / 100);
          win_min_cyc_q <= 16'(khz_to_cyc(WIN_450_MAX_KHZ));
          win_max_cyc_q <= 16'(khz_to_cyc(WIN_450_MIN_KHZ));
        end
        // Reserved code behaves as the 300 kHz setting
        default: begin
          nom_cyc_q <= 16'(khz_to_cyc(FSW_300_KHZ));
          span_cyc_q <= 16'(khz_to_cyc(FSW_300_KHZ) * DITHER_SPAN_PCT / 100);
          win_min_cyc_q <= 16'(khz_to_cyc(WIN_300_MAX_KHZ));
          win_max_cyc_q <= 16'(khz_to_cyc(WIN_300_MIN_KHZ));
        end
      endcase
    end
  end
endmodule : period_window

// [src/sw_clock_ctrl.sv]
// Purpose: Switching clock, dither, sync pin, soft-start and protection control.
// Assumes: One 200 MHz clock; sync pin and flags are asynchronous inputs.
// Notes: Sync pin is three signals; output enable is low while driving.
// How it works
// - Three selectable switching frequencies: 300/400/450 kHz
// - Dither sweeps period about ten percent, triangular
// - Dither rate selectable, 10 or 25 kHz
// - One triangle sweep lasts one modulation period
// - Control bit picks sync pin direction
// - Sync output runs near fifty percent duty
// - Sync output carries the same dither
// - Sync output phase 0, 90, 120, 180
// - Lock to external clock when in window
// - External clock outside window means internal fallback
// - Relock after eight consecutive good periods
// - No dither while fallen back in input mode
// - Input overvoltage stops switching, low output switch on
// - Resume switching once input overvoltage clears
// - Output code twelve bits, 20 mV steps
// - Soft-start ramps code from zero to 5 V
// - Four droop ranges, off during supply contracts
// - Output overvoltage turns all switches off until falling
// - Current limit code seven bits, 50 mA steps
//
// The register offsets and strobed register access were decided locally.
module sw_clock_ctrl
  import sw_clock_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe_n,
  input wire logic vin_ov,
  input wire logic vout_ov_rise,
  input wire logic vout_ov_fall,
  output logic sw_clk,
  output logic switching_en,
  output logic input_high_side_switch,
  output logic input_low_side_switch,
  output logic output_high_side_switch,
  output logic output_low_side_switch,
  output logic [11:0] output_voltage_code,
  output logic [6:0] current_limit_code,
  output logic [1:0] droop_comp_range,
  output logic droop_en
);
  logic [12:0] ctrl_q;
  logic [11:0] vout_target_q;
  logic [6:0] ilim_q;
  logic [15:0] nom_cyc, span_cyc, win_min_cyc, win_max_cyc;
  fsel_t fsel;
  phase_t phase;
  logic dither_en, dither_fast, sync_out_mode;

  assign fsel = fsel_t'(ctrl_q[CTRL_FSEL_LO +: 2]);
  assign phase = phase_t'(ctrl_q[CTRL_PHASE_LO +: 2]);
  assign dither_en = ctrl_q[CTRL_DITHER_EN];
  assign dither_fast = ctrl_q[CTRL_DITHER_FAST];
  assign sync_out_mode = ctrl_q[CTRL_SYNC_OUT];

  period_window u_win (
    .clk(clk),
    .rstn(rstn),
    .fsel(fsel),
    .nom_cyc_q(nom_cyc),
    .span_cyc_q(span_cyc),
    .win_min_cyc_q(win_min_cyc),
    .win_max_cyc_q(win_max_cyc)
  );

  // Register writes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RESET;
      vout_target_q <= 12'h000;
      ilim_q <= ILIM_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: ctrl_q <= reg_wdata[12:0];
        REG_VOUT: vout_target_q <= reg_wdata[11:0];
        REG_ILIM: ilim_q <= reg_wdata[6:0];
        default: ;
      endcase
    end
  end

  // Input synchronisers: first stage feeds only the second
  logic [1:0] sync_in_s, vin_ov_s, ovr_s, ovf_s;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_in_s <= 2'b00;
      vin_ov_s <= 2'b00;
      ovr_s <= 2'b00;
      ovf_s <= 2'b00;
    end else begin
      sync_in_s <= {sync_in_s[0], sync_in};
      vin_ov_s <= {vin_ov_s[0], vin_ov};
      ovr_s <= {ovr_s[0], vout_ov_rise};
      ovf_s <= {ovf_s[0], vout_ov_fall};
    end
  end
  logic sync_prev_q;
  logic ext_edge;
  always_ff @(posedge clk) begin
    if (!rstn) sync_prev_q <= 1'b0;
    else sync_prev_q <= sync_in_s[1];
  end
  assign ext_edge = sync_in_s[1] & ~sync_prev_q;

  // External period check
  logic [15:0] ext_cnt_q;
  logic [3:0] good_cnt_q;
  logic ext_ok_q;
  logic period_good;
  assign period_good = (ext_cnt_q >= win_min_cyc) && (ext_cnt_q <= win_max_cyc);
  always_ff @(posedge clk) begin
    if (!rstn || sync_out_mode) begin
      ext_cnt_q <= 16'h0000;
      good_cnt_q <= 4'h0;
      ext_ok_q <= 1'b0;
    end else if (ext_edge) begin
      ext_cnt_q <= 16'h0001;
      if (!period_good) begin
        good_cnt_q <= 4'h0;
        ext_ok_q <= 1'b0;
      end else if (good_cnt_q == 4'(RELOCK_COUNT - 1)) begin
        ext_ok_q <= 1'b1;
      end else begin
        good_cnt_q <= good_cnt_q + 4'h1;
      end
    end else if (ext_cnt_q > win_max_cyc) begin
      // Lost clock: fail without waiting for an edge
      ext_cnt_q <= 16'h0000;
      good_cnt_q <= 4'h0;
      ext_ok_q <= 1'b0;
    end else if (ext_cnt_q != 16'h0000) begin
      ext_cnt_q <= ext_cnt_q + 16'h0001;
    end
  end

  // Triangular dither offset
  logic [15:0] tri_cnt_q, tri_len, tri_off;
  logic tri_up_q;
  logic dither_act;
  logic use_ext_q;
  // Input mode never dithers, so a fallen-back clock stays clean
  assign dither_act = dither_en && sync_out_mode;
  assign tri_len = dither_fast ? 16'(khz_to_cyc(DITHER_FAST_KHZ) / 2)
                               : 16'(khz_to_cyc(DITHER_SLOW_KHZ) / 2);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tri_cnt_q <= 16'h0000;
      tri_up_q <= 1'b1;
    end else if (tri_cnt_q >= tri_len - 16'h0001) begin
      tri_cnt_q <= 16'h0000;
      tri_up_q <= ~tri_up_q;
    end else begin
      tri_cnt_q <= tri_cnt_q + 16'h0001;
    end
  end
  // Offset spans 0..2*span across each half sweep
  assign tri_off = 16'((32'(tri_up_q ? tri_cnt_q : tri_len - tri_cnt_q) * 32'(span_cyc) * 2)
                       / 32'(tri_len));

  // Internal oscillator with cycle-boundary source switching
  logic [15:0] per_cnt_q, cur_per_q;
  logic cycle_end;
  assign cycle_end = (per_cnt_q >= cur_per_q - 16'h0001);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      per_cnt_q <= 16'h0000;
      cur_per_q <= 16'(khz_to_cyc(FSW_300_KHZ));
      use_ext_q <= 1'b0;
    end else if (use_ext_q) begin
      if (ext_edge && period_good && ext_ok_q) begin
        // Only a good external edge ends the cycle, so a bad one cuts no pulse
        per_cnt_q <= 16'h0000;
        cur_per_q <= nom_cyc;
      end else if (!ext_ok_q && cycle_end) begin
        // A failed source is dropped at the nominal cycle end
        per_cnt_q <= 16'h0000;
        use_ext_q <= 1'b0;
        cur_per_q <= nom_cyc;
      end else if (per_cnt_q != 16'hffff) begin
        per_cnt_q <= per_cnt_q + 16'h0001;
      end
    end else if (cycle_end) begin
      per_cnt_q <= 16'h0000;
      use_ext_q <= ext_ok_q && !sync_out_mode;
      // Dither suppressed when fallen back from external clock
      cur_per_q <= dither_act
                   ? 16'(nom_cyc - span_cyc + tri_off) : nom_cyc;
    end else begin
      per_cnt_q <= per_cnt_q + 16'h0001;
    end
  end
  // Half-period duty; in external mode uses nominal half
  always_ff @(posedge clk) begin
    if (!rstn) sw_clk <= 1'b0;
    else sw_clk <= (per_cnt_q < (cur_per_q >> 1));
  end

  // Phase-shifted sync output follows the live cycle, dither included
  logic [15:0] ph_off;
  logic [15:0] ph_pos;
  always_comb begin
    unique case (phase)
      PH_0: ph_off = 16'h0000;
      PH_90: ph_off = cur_per_q >> 2;
      PH_120: ph_off = 16'(32'(cur_per_q) / 3);
      PH_180: ph_off = cur_per_q >> 1;
    endcase
  end
  assign ph_pos = (per_cnt_q >= ph_off) ? 16'(per_cnt_q - ph_off)
                                        : 16'(per_cnt_q + cur_per_q - ph_off);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_out <= 1'b0;
      sync_oe_n <= 1'b1;
    end else begin
      sync_out <= sync_out_mode && (ph_pos < (cur_per_q >> 1));
      sync_oe_n <= ~sync_out_mode;
    end
  end

  // Protection: switch states
  logic out_ov_q;
  always_ff @(posedge clk) begin
    if (!rstn) out_ov_q <= 1'b0;
    else if (ovr_s[1]) out_ov_q <= 1'b1;
    else if (ovf_s[1]) out_ov_q <= 1'b0;
  end
  logic run;
  assign run = ctrl_q[CTRL_RUN] && !vin_ov_s[1] && !out_ov_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      switching_en <= 1'b0;
      input_high_side_switch <= 1'b0;
      input_low_side_switch <= 1'b0;
      output_high_side_switch <= 1'b0;
      output_low_side_switch <= 1'b0;
    end else begin
      switching_en <= run;
      input_high_side_switch <= run;
      input_low_side_switch <= 1'b0;
      output_high_side_switch <= run;
      // Input OV clamps the output low switch on; output OV keeps all off
      output_low_side_switch <= vin_ov_s[1] && !out_ov_q;
    end
  end

  // Soft-start ramp
  logic [15:0] ss_div_q;
  logic ss_tick;
  logic ss_active_q;
  assign ss_tick = (ss_div_q == 16'(SS_STEP_CYC - 1));
  always_ff @(posedge clk) begin
    if (!rstn || ss_tick) ss_div_q <= 16'h0000;
    else ss_div_q <= ss_div_q + 16'h0001;
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      output_voltage_code <= 12'h000;
      ss_active_q <= 1'b0;
    end else if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_SS_START]) begin
      output_voltage_code <= 12'h000;
      ss_active_q <= 1'b1;
    end else if (ss_active_q) begin
      if (output_voltage_code >= VOUT_SS_CODE) ss_active_q <= 1'b0;
      else if (ss_tick) output_voltage_code <= output_voltage_code + 12'h001;
    end else begin
      output_voltage_code <= vout_target_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      current_limit_code <= ILIM_RESET;
      droop_comp_range <= 2'b00;
      droop_en <= 1'b0;
    end else begin
      current_limit_code <= ilim_q;
      droop_comp_range <= ctrl_q[CTRL_DROOP_LO +: 2];
      droop_en <= ctrl_q[CTRL_DROOP_EN] && !ctrl_q[CTRL_PPS];
    end
  end

  // Read port, data one cycle after strobe
  always_ff @(posedge clk) begin
    if (!rstn) reg_rdata <= 32'h0000_0000;
    else if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: reg_rdata <= {19'h00000, ctrl_q};
        REG_VOUT: reg_rdata <= {20'h00000, output_voltage_code};
        REG_ILIM: reg_rdata <= {25'h0000000, ilim_q};
        REG_STATUS: reg_rdata <= {27'h0000000, ss_active_q, out_ov_q, vin_ov_s[1],
                                  ext_ok_q, use_ext_q};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else reg_rdata <= 32'h0000_0000;
  end

  relock_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(ext_ok_q) |-> $past(ext_edge)) else $error("relock without edge");
  fail_fast_a: assert property (@(posedge clk) disable iff (!rstn)
    (ext_edge && !period_good && !sync_out_mode) |=> !ext_ok_q)
    else $error("bad period not failed");
  vin_ov_a: assert property (@(posedge clk) disable iff (!rstn)
    (vin_ov_s[1] && !out_ov_q) |=> (output_low_side_switch && !input_high_side_switch))
    else $error("input ov switch state");
  out_ov_a: assert property (@(posedge clk) disable iff (!rstn)
    out_ov_q |=> !output_low_side_switch && !output_high_side_switch)
    else $error("output ov switch state");
  oe_mode_a: assert property (@(posedge clk) disable iff (!rstn)
    sync_out_mode |=> !sync_oe_n) else $error("sync oe wrong");
  no_out_a: assert property (@(posedge clk) disable iff (!rstn)
    !sync_out_mode |=> !sync_out) else $error("sync driven in input mode");
  ramp_mono_a: assert property (@(posedge clk) disable iff (!rstn)
    (ss_active_q && $past(ss_active_q)) |-> output_voltage_code >= $past(output_voltage_code))
    else $error("ramp not monotonic");
  resume_a: assert property (@(posedge clk) disable iff (!rstn)
    (run && ctrl_q[CTRL_RUN]) |=> switching_en) else $error("no resume");
  pps_droop_a: assert property (@(posedge clk) disable iff (!rstn)
    ctrl_q[CTRL_PPS] |=> !droop_en) else $error("droop on in pps");
  plain_in_a: assert property (@(posedge clk) disable iff (!rstn)
    (cycle_end && !use_ext_q && !sync_out_mode) |=> cur_per_q == $past(nom_cyc))
    else $error("dither in input mode");
  drop_edge_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(use_ext_q) |-> $past(cycle_end)) else $error("source dropped mid cycle");
  take_ext_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(use_ext_q) |-> $past(ext_ok_q) && $past(cycle_end)) else $error("early external");
  ext_lock_c: cover property (@(posedge clk) $rose(use_ext_q));
  fallback_c: cover property (@(posedge clk) $fell(use_ext_q));
  vin_ov_c: cover property (@(posedge clk) $rose(vin_ov_s[1]));
  ramp_done_c: cover property (@(posedge clk) $fell(ss_active_q));
endmodule : sw_clock_ctrl

// [verif/sync_clock_source.sv]
// Purpose: External clock source standing on the far side of the sync pin.
// Assumes: Period given in ns; the source may be switched off at any time.
// Notes: A stopped source drives low, the level of a quiet clock line.
module sync_clock_source (
  input wire logic enable,
  input wire logic [31:0] period_ns,
  output logic clk_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial clk_out = 1'b0;
  // The bench sets in-window or out-of-window periods on purpose
  always begin
    if (enable && period_ns > 0) begin
      clk_out = 1'b1;
      #(period_ns / 2.0);
      clk_out = 1'b0;
      #(period_ns / 2.0);
    end else begin
      clk_out = 1'b0;
      @(enable or period_ns);
    end
  end
endmodule : sync_clock_source

// [verif/test_sw_clock_ctrl.sv]
// Purpose: Self-checking bench for the switching clock control block.
// Assumes: 200 MHz clk; a clock source model sits on the pin in input mode.
// Notes: Soft-start alone takes about 50k cycles, so other tests stay short.
module test_sw_clock_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import sw_clock_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sync_in = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic vin_ov = 1'b0, vout_ov_rise = 1'b0, vout_ov_fall = 1'b0, src_en = 1'b0;
  logic sync_out, sync_oe_n, sw_clk, switching_en, ihs, ils, ohs, ols, droop_en, src_clk;
  logic [11:0] output_voltage_code;
  logic [6:0] current_limit_code;
  logic [1:0] droop_comp_range;
  int unsigned src_ns = 2400;
  int num_errors = 0, samples_checked = 0, cycles = 0;

  always #2.5 clk = ~clk;
  // Pin level: the block drives it only while its enable is low
  always @(posedge clk) sync_in <= (sync_oe_n === 1'b0) ? sync_out : src_clk;

  sw_clock_ctrl u_sw_clock_ctrl (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sync_in(sync_in), .sync_out(sync_out), .sync_oe_n(sync_oe_n), .vin_ov(vin_ov),
    .vout_ov_rise(vout_ov_rise), .vout_ov_fall(vout_ov_fall), .sw_clk(sw_clk),
    .switching_en(switching_en), .input_high_side_switch(ihs), .input_low_side_switch(ils),
    .output_high_side_switch(ohs), .output_low_side_switch(ols),
    .output_voltage_code(output_voltage_code), .current_limit_code(current_limit_code),
    .droop_comp_range(droop_comp_range), .droop_en(droop_en));
  sync_clock_source u_sync_clock_source (.enable(src_en), .period_ns(src_ns),
    .clk_out(src_clk));

  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cycles++;
    if (cycles == 99000) begin
      num_errors++;
      $display("ERROR %0t run too long", $time);
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Distance taken round the period when md is positive, for phase offsets
  task automatic check_near(input int seen, input int exp, input int tol, input int md,
                            input string what);
    int dd;
    dd = seen > exp ? seen - exp : exp - seen;
    if (md > 0 && dd > md / 2) dd = md - dd;
    check(32'(dd <= tol), 32'h1, what);
  endtask : check_near

  task automatic reg_write(input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] rd);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rd = reg_rdata;
  endtask : reg_read

  // Cycles from a rise of clock a to the next rise of clock b, which may be the same clock (1 = sync_out)
  task automatic edge_gap(input bit a_sync, input bit b_sync, output int p);
    logic a, b, pa, pb;
    bit started;
    p = 0;
    started = 0;
    pa = 1'b1;
    pb = 1'b1;
    while (p < 9000) begin
      @(negedge clk);
      a = a_sync ? sync_out : sw_clk;
      b = b_sync ? sync_out : sw_clk;
      if (started) begin
        p++;
        if (b === 1'b1 && pb === 1'b0) break;
      end else if (a === 1'b1 && pa === 1'b0) started = 1;
      pa = a;
      pb = b;
    end
  endtask : edge_gap

  task automatic test_regs();
    reg_read(REG_CTRL, d);
    check(d, 32'h0, "ctrl reset");
    reg_read(8'h10, d);
    check(d, 32'h0, "unmapped");
    // Firmware owns the peak limit pairing, buck just below boost
    reg_write(REG_ILIM, 32'hffffffff);
    reg_read(REG_ILIM, d);
    check(d, 32'h0000007f, "ilim width");
    check(32'(current_limit_code), 32'h0000007f, "ilim port");
    reg_write(REG_CTRL, 32'h00000600);
    repeat (2) @(negedge clk);
    check({droop_en, droop_comp_range}, 3'h6, "droop");
    reg_write(REG_CTRL, 32'h00000e00);
    repeat (2) @(negedge clk);
    check({droop_en, droop_comp_range}, 3'h2, "pps droop off");
    $display("test regs done");
  endtask : test_regs

  task automatic test_soft_start();
    logic [11:0] prev;
    int n;
    bit mono;
    // 5 V at 20 mV a step is code 250
    reg_write(REG_VOUT, 32'h000000fa);
    reg_write(REG_CTRL, 32'h00001080);
    @(negedge clk);
    prev = 12'h000;
    mono = 1;
    n = 0;
    while (output_voltage_code !== 12'h0fa && n < 60000) begin
      @(negedge clk);
      n++;
      if (output_voltage_code < prev || output_voltage_code - prev > 1) mono = 0;
      prev = output_voltage_code;
    end
    check(output_voltage_code, 12'h0fa, "ss end");
    check(mono, 1'b1, "ss ramp");
    check_near(n, 50000, 600, 0, "ss time");
    reg_write(REG_VOUT, 32'hffffffff);
    reg_read(REG_VOUT, d);
    check(d, 32'h00000fff, "vout width");
    $display("test soft start done");
  endtask : test_soft_start

  task automatic test_freq();
    int p, hi, ep;
    for (int f = 0; f < 3; f++) begin
      ep = 200000 / (f == 0 ? 300 : f == 1 ? 400 : 450);
      reg_write(REG_CTRL, 32'h00001010 | 32'(f));
      edge_gap(0, 0, p);
      edge_gap(0, 0, p);
      check_near(p, ep, 2, 0, "period");
      hi = 0;
      repeat (ep) begin
        @(negedge clk);
        hi += (sync_out === 1'b1);
      end
      check_near(hi, ep / 2, 3, 0, "duty");
      check(sync_oe_n, 1'b0, "drives pin");
    end
    $display("test freq done");
  endtask : test_freq

  task automatic test_phase();
    int p, e;
    for (int ph = 0; ph < 4; ph++) begin
      reg_write(REG_CTRL, 32'h00001012 | (32'(ph) << 5));
      edge_gap(0, 0, p);
      edge_gap(0, 1, p);
      e = 444 * (ph == 0 ? 0 : ph == 1 ? 90 : ph == 2 ? 120 : 180) / 360;
      check_near(p % 444, e, 4, 444, "phase");
    end
    $display("test phase done");
  endtask : test_phase

  // 450 kHz, fast dither: periods span about 400 to 488 cycles
  task automatic test_dither();
    int p, mn[2], mx[2], last[2];
    logic pv[2];
    logic v;
    mn = '{9999, 9999};
    mx = '{0, 0};
    last = '{0, 0};
    pv = '{1'b1, 1'b1};
    reg_write(REG_CTRL, 32'h0000101e);
    // Every period of both clocks over more than one sweep; the phase change settles first
    for (int n = 0; n < 10000; n++) begin
      @(negedge clk);
      for (int s = 0; s < 2; s++) begin
        v = s ? sync_out : sw_clk;
        if (v === 1'b1 && pv[s] === 1'b0) begin
          p = n - last[s];
          if (n > 1000 && p < mn[s]) mn[s] = p;
          if (n > 1000 && p > mx[s]) mx[s] = p;
          last[s] = n;
        end
        pv[s] = v;
      end
    end
    for (int s = 0; s < 2; s++) begin
      check_near(mn[s], 404, 20, 0, "dither min");
      check_near(mx[s], 494, 20, 0, "dither max");
    end
    $display("test dither done");
  endtask : test_dither

  task automatic test_sync();
    int p;
    src_en <= 1'b1;
    reg_write(REG_CTRL, 32'h00001005);
    repeat (2) @(negedge clk);
    check(sync_oe_n, 1'b1, "pin released");
    repeat (12 * 480) @(posedge clk);
    reg_read(REG_STATUS, d);
    check(d & 32'h3, 32'h3, "locked");
    edge_gap(0, 0, p);
    edge_gap(0, 0, p);
    check_near(p, 480, 3, 0, "ext period");
    src_ns <= 160;
    // The source finishes its current half period before the short one starts
    repeat (600) @(posedge clk);
    reg_read(REG_STATUS, d);
    check(d & 32'h2, 32'h0, "bad seen");
    repeat (1100) @(posedge clk);
    reg_read(REG_STATUS, d);
    check(d & 32'h1, 32'h0, "fallback");
    repeat (2) begin
      edge_gap(0, 0, p);
      check_near(p, 500, 2, 0, "no dither");
    end
    src_ns <= 2400;
    repeat (6 * 480) @(posedge clk);
    reg_read(REG_STATUS, d);
    check(d & 32'h1, 32'h0, "early relock");
    repeat (7 * 480) @(posedge clk);
    reg_read(REG_STATUS, d);
    check(d & 32'h1, 32'h1, "relock");
    src_en <= 1'b0;
    $display("test sync done");
  endtask : test_sync

  task automatic test_ov();
    reg_write(REG_CTRL, 32'h00001000);
    vin_ov <= 1'b1;
    repeat (8) @(posedge clk);
    check({switching_en, ihs, ils, ohs, ols}, 5'h01, "vin ov");
    vin_ov <= 1'b0;
    repeat (8) @(posedge clk);
    check(switching_en, 1'b1, "vin ov gone");
    vout_ov_rise <= 1'b1;
    repeat (8) @(posedge clk);
    vout_ov_rise <= 1'b0;
    repeat (8) @(posedge clk);
    check({switching_en, ihs, ils, ohs, ols}, 5'h00, "out ov held");
    vout_ov_fall <= 1'b1;
    repeat (8) @(posedge clk);
    check(switching_en, 1'b1, "out ov gone");
    vout_ov_fall <= 1'b0;
    $display("test ov done");
  endtask : test_ov

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    test_regs();
    test_soft_start();
    test_freq();
    test_phase();
    test_dither();
    test_sync();
    test_ov();
    give_verdict();
  end
endmodule : test_sw_clock_ctrl
